// ==== qdec_pkg.sv ====
// Package with register map, field layout and constants of the quadrature position decoder
package qdec_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	// Register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_LIMIT = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_POS = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_STAT = 4'hc;
	// Control fields
	localparam int CTL_ENABLE = 0;
	localparam int CTL_BOTH_EDGES = 1;
	localparam int CTL_INDEX_RESET = 2;
	localparam int CTL_STEP_DIR = 3;
	localparam int CTL_SWAP = 4;
	localparam int CTL_VEL_EN = 5;
	localparam int CTL_PREDIV_LSB = 8;
	localparam int CTL_PREDIV_W = 3;
	localparam int CTL_W = 11;
	// Event bit positions (status, mask and clear share them)
	localparam int EV_INDEX = 0;
	localparam int EV_TIMER = 1;
	localparam int EV_DIR = 2;
	localparam int EV_ERROR = 3;
	localparam int EV_N = 4;
	localparam int STAT_DIR_BIT = 8;
	localparam int STAT_ERRFLAG_BIT = 9;
	localparam logic [DATA_W-1:0] RESET_LIMIT = 32'hffffffff;
	localparam logic [DATA_W-1:0] RESET_PERIOD = 32'h00000001;
	localparam logic [DATA_W-1:0] DIR_FWD = 32'h00000001;
	localparam logic [DATA_W-1:0] DIR_REV = 32'hffffffff;
endpackage

// ==== qdec_velocity.sv ====
`timescale 1ns/100ps
// Velocity unit: predivider, period timer and pulse accumulator
module qdec_velocity
	import qdec_pkg::*;
#(
	parameter int CNT_W = 32
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic run,
	input wire logic count_pulse,
	input wire logic [CTL_PREDIV_W-1:0] velocity_predivider,
	input wire logic [CNT_W-1:0] velocity_period_length,
	output logic [CNT_W-1:0] running_total,
	output logic [CNT_W-1:0] last_total,
	output logic period_done
);
	logic [7:0] prediv_cnt;
	logic [CNT_W-1:0] timer;
	wire [7:0] prediv_top = 8'(8'h01 << velocity_predivider) - 8'h01;
	wire div_pulse = count_pulse && (prediv_cnt == prediv_top);
	// Zero period treated as one to avoid a stuck timer
	wire expire = run && (timer + CNT_W'(1) >= velocity_period_length);

	// Predivider: one divided pulse per 2^n counted edges
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			prediv_cnt <= 8'h00;
		end else if (!run) begin
			prediv_cnt <= 8'h00;
		end else if (count_pulse) begin
			prediv_cnt <= div_pulse ? 8'h00 : prediv_cnt + 8'h01;
		end
	end

	// Period timer and accumulator; save and clear on expiry
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			timer <= '0;
			running_total <= '0;
			last_total <= '0;
			period_done <= 1'b0;
		end else begin
			period_done <= expire;
			if (!run) begin
				timer <= '0;
				running_total <= '0;
			end else if (expire) begin
				timer <= '0;
				last_total <= running_total + CNT_W'(div_pulse);
				running_total <= '0;
			end else begin
				timer <= timer + CNT_W'(1);
				running_total <= running_total + CNT_W'(div_pulse);
			end
		end
	end

	a_total_clears: assert property (@(posedge clk_sys) disable iff (!arst_n)
		expire |=> running_total == '0)
		else $error("Accumulator not cleared at period end");
	a_idle_no_count: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!run |=> running_total == '0 && !period_done)
		else $error("Velocity counted while stopped");
	a_last_latch: assert property (@(posedge clk_sys) disable iff (!arst_n)
		expire |=> last_total == $past(running_total) + CNT_W'($past(div_pulse)))
		else $error("Period total not saved");
endmodule // qdec_velocity

// ==== qdec_top.sv ====
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
// Quadrature position decoder: decoding, position counter, events and register port
module qdec_top
	import qdec_pkg::*;
#(
	parameter int POS_W = 32
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic phase_input_first,
	input wire logic phase_input_second,
	input wire logic index_in,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [DATA_W-1:0] reg_rdata,
	output logic irq
);

	typedef enum logic [1:0] {
		DIR_IS_FWD = 2'b01,
		DIR_IS_REV = 2'b10
	} dir_t;

	logic [CTL_W-1:0] ctrl;
	logic [POS_W-1:0] position_limit;
	logic [POS_W-1:0] position;
	logic [DATA_W-1:0] velocity_period_length;
	logic [EV_N-1:0] ev_raw;
	logic [EV_N-1:0] ev_mask;
	logic error_flag;
	dir_t dir_state;
	logic prev_a;
	logic prev_b;
	logic prev_idx;
	logic [DATA_W-1:0] vel_running;
	logic [DATA_W-1:0] vel_last;
	logic vel_done;

	// Register map, all word aligned (extra offsets placed past the status word)
	localparam logic [3:0] IDX_CTRL = 4'h0;
	localparam logic [3:0] IDX_LIMIT = 4'h1;
	localparam logic [3:0] IDX_POS = 4'h2;
	localparam logic [3:0] IDX_STAT = 4'h3;
	localparam logic [3:0] IDX_MASK = 4'h4;
	localparam logic [3:0] IDX_CLEAR = 4'h5;
	localparam logic [3:0] IDX_PERIOD = 4'h6;
	localparam logic [3:0] IDX_VRUN = 4'h7;
	localparam logic [3:0] IDX_VLAST = 4'h8;
	localparam logic [3:0] IDX_DIR = 4'h9;
	localparam logic [3:0] IDX_MSTAT = 4'ha;

	// Address here is a word index; bus address bits give the index directly
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] idx);
		hit = (a == idx);
	endfunction

	wire en = ctrl[CTL_ENABLE];
	wire both_edges = ctrl[CTL_BOTH_EDGES];
	wire idx_reset = ctrl[CTL_INDEX_RESET];
	wire step_dir = ctrl[CTL_STEP_DIR];
	wire swap = ctrl[CTL_SWAP];
	wire vel_en = ctrl[CTL_VEL_EN];

	// Exchange applied before any decoding, in both modes
	wire ch_a = swap ? phase_input_second : phase_input_first;
	wire ch_b = swap ? phase_input_first : phase_input_second;
	wire a_edge = ch_a ^ prev_a;
	wire b_edge = ch_b ^ prev_b;
	wire idx_rise = index_in && !prev_idx;

	// Phase mode: after an A edge, A != B means A leads (forward)
	wire phase_fwd = a_edge ? (ch_a != ch_b) : (ch_a == ch_b);
	wire phase_err = a_edge && b_edge;
	wire phase_cnt = !phase_err && (a_edge || (both_edges && b_edge));
	// Step mode: rising step clock counts, second input is direction
	wire step_cnt = ch_a && !prev_a;
	wire step_fwd = !ch_b;

	// Qualified decode: nothing counts, turns or flags while disabled
	wire count_pulse = en && (step_dir ? step_cnt : phase_cnt);
	wire move_fwd = step_dir ? step_fwd : phase_fwd;
	wire seen_err = en && !step_dir && phase_err;
	wire motion_seen = en && (step_dir ? step_cnt : (a_edge || b_edge) && !phase_err);
	wire dir_now_fwd = (dir_state == DIR_IS_FWD);
	wire dir_change = motion_seen && (move_fwd != dir_now_fwd);
	wire index_event = en && idx_rise;

	// Next position: wrap at both limits, index reload, software load
	// Compare with >= so a limit lowered below the count still wraps to zero
	wire at_top = (position >= position_limit);
	wire at_zero = (position == '0);
	wire [POS_W-1:0] pos_up = at_top ? '0 : position + POS_W'(1);
	wire [POS_W-1:0] pos_dn = at_zero ? position_limit : position - POS_W'(1);
	wire [POS_W-1:0] next_position = !count_pulse ? position : (move_fwd ? pos_up : pos_dn);
	wire index_load = index_event && idx_reset;
	wire [POS_W-1:0] index_value = dir_now_fwd ? '0 : position_limit;

	// Event sources gathered in status bit order
	wire [EV_N-1:0] ev_set = {seen_err, dir_change, vel_done, index_event};
	wire clear_wr = reg_write && hit(reg_addr, IDX_CLEAR);
	wire [EV_N-1:0] ev_clr = clear_wr ? reg_wdata[EV_N-1:0] : '0;

	// Input history runs while disabled too, so enable starts from settled samples
	// Swap changes move the inputs, so make them with the decoder disabled
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			prev_a <= 1'b0;
			prev_b <= 1'b0;
			prev_idx <= 1'b0;
		end else begin
			prev_a <= ch_a;
			prev_b <= ch_b;
			prev_idx <= index_in;
		end
	end

	// Configuration registers written by software
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ctrl <= '0;
			position_limit <= RESET_LIMIT[POS_W-1:0];
			velocity_period_length <= RESET_PERIOD;
			ev_mask <= '0;
		end else if (reg_write) begin
			if (hit(reg_addr, IDX_CTRL)) ctrl <= reg_wdata[CTL_W-1:0];
			if (hit(reg_addr, IDX_LIMIT)) position_limit <= reg_wdata[POS_W-1:0];
			if (hit(reg_addr, IDX_PERIOD)) velocity_period_length <= reg_wdata;
			if (hit(reg_addr, IDX_MASK)) ev_mask <= reg_wdata[EV_N-1:0];
		end
	end

	// Position counter: software load wins, then index, then counting
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			position <= '0;
		end else if (reg_write && hit(reg_addr, IDX_POS)) begin
			position <= reg_wdata[POS_W-1:0];
		end else if (index_load) begin
			position <= index_value;
		end else begin
			position <= next_position;
		end
	end

	// Direction holds last motion; error flag sticky until cleared
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			dir_state <= DIR_IS_FWD;
			error_flag <= 1'b0;
		end else begin
			if (motion_seen) dir_state <= move_fwd ? DIR_IS_FWD : DIR_IS_REV;
			if (seen_err) error_flag <= 1'b1;
			else if (ev_clr[EV_ERROR]) error_flag <= 1'b0;
		end
	end

	// Event status: a set in the same cycle as its clear wins
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ev_raw <= '0;
		end else begin
			ev_raw <= (ev_raw & ~ev_clr) | ev_set;
		end
	end

	// Velocity only runs with both encoder and velocity enabled
	// Predivider field is log2 of the division, so eight settings cover 1 to 128
	qdec_velocity #(
		.CNT_W(DATA_W)
	) u_velocity (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.run(en && vel_en),
		.count_pulse(count_pulse),
		.velocity_predivider(ctrl[CTL_PREDIV_LSB +: CTL_PREDIV_W]),
		.velocity_period_length(velocity_period_length),
		.running_total(vel_running),
		.last_total(vel_last),
		.period_done(vel_done)
	);

	// Read selection; unmapped addresses read zero
	wire [EV_N-1:0] ev_masked = ev_raw & ev_mask;
	wire [DATA_W-1:0] dir_word = dir_now_fwd ? DIR_FWD : DIR_REV;
	wire [DATA_W-1:0] stat_word = DATA_W'(ev_raw) | (DATA_W'(!dir_now_fwd) << STAT_DIR_BIT)
		| (DATA_W'(error_flag) << STAT_ERRFLAG_BIT);
	wire [DATA_W-1:0] read_mux =
		hit(reg_addr, IDX_CTRL) ? DATA_W'(ctrl) :
		hit(reg_addr, IDX_LIMIT) ? DATA_W'(position_limit) :
		hit(reg_addr, IDX_POS) ? DATA_W'(position) :
		hit(reg_addr, IDX_STAT) ? stat_word :
		hit(reg_addr, IDX_MASK) ? DATA_W'(ev_mask) :
		hit(reg_addr, IDX_PERIOD) ? velocity_period_length :
		hit(reg_addr, IDX_VRUN) ? vel_running :
		hit(reg_addr, IDX_VLAST) ? vel_last :
		hit(reg_addr, IDX_DIR) ? dir_word :
		hit(reg_addr, IDX_MSTAT) ? DATA_W'(ev_masked) : '0;

	// Read data registered, valid only in the cycle after the strobe
	// Interrupt registered so a mask or clear write cannot glitch the line
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= '0;
			irq <= 1'b0;
		end else begin
			reg_rdata <= reg_read ? read_mux : '0;
			irq <= |ev_masked;
		end
	end

	// Position, index, event, direction and read timing checks
	a_disabled_still: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!en && !reg_write |=> $stable(position))
		else $error("Position moved while disabled");
	a_index_abs_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
		index_load && dir_now_fwd && !(reg_write && hit(reg_addr, IDX_POS)) |=> position == '0)
		else $error("Index did not clear position");
	a_index_rev_limit: assert property (@(posedge clk_sys) disable iff (!arst_n)
		index_load && !dir_now_fwd && !(reg_write && hit(reg_addr, IDX_POS)) |=> position == $past(position_limit))
		else $error("Reverse index did not load limit");
	a_rel_no_reset: assert property (@(posedge clk_sys) disable iff (!arst_n)
		index_event && !idx_reset && !count_pulse && !reg_write |=> $stable(position))
		else $error("Index changed relative position");
	a_pos_load: assert property (@(posedge clk_sys) disable iff (!arst_n)
		reg_write && hit(reg_addr, IDX_POS) |=> position == $past(reg_wdata[POS_W-1:0]))
		else $error("Position write not loaded");
	a_wrap_up: assert property (@(posedge clk_sys) disable iff (!arst_n)
		count_pulse && move_fwd && at_top && !index_load && !reg_write |=> position == '0)
		else $error("Forward wrap wrong");
	a_err_flag: assert property (@(posedge clk_sys) disable iff (!arst_n)
		seen_err |=> error_flag && ev_raw[EV_ERROR] ##1 error_flag || $past(ev_clr[EV_ERROR]))
		else $error("Error flag not set");
	a_set_wins: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ev_set[EV_DIR] |=> ev_raw[EV_DIR])
		else $error("Direction event lost");
	a_dir_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!motion_seen |=> $stable(dir_state))
		else $error("Direction changed without motion");
	a_irq_masked: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ev_raw == '0 ##1 ev_raw == '0 |-> !irq)
		else $error("Interrupt with no pending event");
	a_read_timing: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!reg_read |=> reg_rdata == '0)
		else $error("Read data outside read cycle");

	// Decoding: the leading channel sets direction, step mode, edge choice and swap
	a_phase_lead: assert property (@(posedge clk_sys) disable iff (!arst_n)
		en && !step_dir && a_edge && !b_edge && ch_a != ch_b |=> dir_state == DIR_IS_FWD)
		else $error("First channel leading not taken as forward");
	a_phase_lag: assert property (@(posedge clk_sys) disable iff (!arst_n)
		en && !step_dir && a_edge && !b_edge && ch_a == ch_b |=> dir_state == DIR_IS_REV)
		else $error("Second channel leading not taken as reverse");
	a_step_up: assert property (@(posedge clk_sys) disable iff (!arst_n)
		en && step_dir && ch_a && !prev_a && !ch_b && !at_top && !index_load && !reg_write |=> position == $past(position) + POS_W'(1))
		else $error("Forward step not counted");
	a_step_rev: assert property (@(posedge clk_sys) disable iff (!arst_n)
		en && step_dir && ch_a && !prev_a && ch_b |=> dir_state == DIR_IS_REV)
		else $error("Step with direction high not reverse");
	a_first_only: assert property (@(posedge clk_sys) disable iff (!arst_n)
		en && !step_dir && !both_edges && b_edge && !a_edge |-> !count_pulse)
		else $error("Second channel edge counted in single edge mode");
	a_both_count: assert property (@(posedge clk_sys) disable iff (!arst_n)
		en && !step_dir && both_edges && b_edge && !a_edge |-> count_pulse)
		else $error("Second channel edge not counted in both edge mode");
	a_swap_lead: assert property (@(posedge clk_sys) disable iff (!arst_n)
		en && !step_dir && swap && $past(swap) && $changed(phase_input_second) && !$changed(phase_input_first)
		|-> move_fwd == (phase_input_second != phase_input_first))
		else $error("Exchanged inputs decoded in the wrong sense");

	// Counting, velocity and events
	a_count_up: assert property (@(posedge clk_sys) disable iff (!arst_n)
		count_pulse && move_fwd && !at_top && !index_load && !reg_write |=> position == $past(position) + POS_W'(1))
		else $error("Forward count wrong");
	a_wrap_down: assert property (@(posedge clk_sys) disable iff (!arst_n)
		count_pulse && !move_fwd && at_zero && !index_load && !reg_write |=> position == $past(position_limit))
		else $error("Reverse wrap wrong");
	a_err_no_count: assert property (@(posedge clk_sys) disable iff (!arst_n)
		seen_err |-> !count_pulse)
		else $error("Phase error counted as motion");
	a_off_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!en |-> !count_pulse && !index_event && !seen_err && !dir_change)
		else $error("Decoder active while disabled");
	a_vel_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!en |=> vel_running == '0 && !vel_done)
		else $error("Velocity ran with the decoder disabled");
	a_timer_event: assert property (@(posedge clk_sys) disable iff (!arst_n)
		vel_done |=> ev_raw[EV_TIMER])
		else $error("Period end not flagged");
	a_index_event: assert property (@(posedge clk_sys) disable iff (!arst_n)
		index_event |=> ev_raw[EV_INDEX])
		else $error("Index not flagged");

	// Register side: clear, mask, interrupt and read words
	a_clear_only: assert property (@(posedge clk_sys) disable iff (!arst_n)
		clear_wr && ev_set == '0 |=> ev_raw == ($past(ev_raw) & ~$past(ev_clr)))
		else $error("Clear touched unselected events");
	a_mask_blocks: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ev_mask == '0 |=> !irq)
		else $error("Interrupt with every source masked");
	a_irq_raise: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(ev_raw & ev_mask) != '0 |=> irq)
		else $error("Enabled pending event gave no interrupt");
	a_dir_word: assert property (@(posedge clk_sys) disable iff (!arst_n)
		reg_read && hit(reg_addr, IDX_DIR) |=> reg_rdata == ($past(dir_state) == DIR_IS_FWD ? DIR_FWD : DIR_REV))
		else $error("Direction word wrong");
	a_read_pos: assert property (@(posedge clk_sys) disable iff (!arst_n)
		reg_read && hit(reg_addr, IDX_POS) |=> reg_rdata == DATA_W'($past(position)))
		else $error("Position read wrong");

	// Scenarios worth seeing in a run
	c_index_load: cover property (@(posedge clk_sys) disable iff (!arst_n) index_load);
	c_dir_flip: cover property (@(posedge clk_sys) disable iff (!arst_n) dir_change);
	c_period: cover property (@(posedge clk_sys) disable iff (!arst_n) vel_done && vel_last != '0);
	c_error: cover property (@(posedge clk_sys) disable iff (!arst_n) seen_err);
	c_step: cover property (@(posedge clk_sys) disable iff (!arst_n) count_pulse && step_dir);
endmodule // qdec_top

// ==== enc_model.sv ====
// Behavioural encoder driving phase, step/direction and index lines
`timescale 1ns/100ps
module enc_model (
	output logic phase_a,
	output logic phase_b,
	output logic index_out,
	input wire logic clk_sys
);
	logic [1:0] pos_idx;
	// Lines start low like a shaft at rest
	initial begin
		phase_a = 1'b0;
		phase_b = 1'b0;
		index_out = 1'b0;
	end
	// Walk 00,10,11,01 is forward with the first line leading
	assign pos_idx = {phase_b, phase_a ^ phase_b};
	// One quarter cycle: a single line moves, so the device sees a clean edge
	task automatic step(input logic rev);
		logic [1:0] n;
		n = rev ? pos_idx - 2'h1 : pos_idx + 2'h1;
		@(posedge clk_sys);
		phase_a <= n[1] ^ n[0];
		phase_b <= n[1];
		repeat (2) @(posedge clk_sys);
	endtask
	// Both lines flip together, which a real encoder only does when faulty
	task automatic both();
		@(posedge clk_sys);
		phase_a <= ~phase_a;
		phase_b <= ~phase_b;
		repeat (2) @(posedge clk_sys);
	endtask
	// Direction settles one cycle before the step clock rises
	task automatic sd(input logic rev);
		@(posedge clk_sys);
		phase_a <= 1'b0;
		phase_b <= rev;
		@(posedge clk_sys);
		phase_a <= 1'b1;
		@(posedge clk_sys);
		phase_a <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask
	// Index pulse of one cycle
	task automatic idx();
		@(posedge clk_sys);
		index_out <= 1'b1;
		@(posedge clk_sys);
		index_out <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask
endmodule // enc_model

// ==== tb_top.sv ====
// Self-checking testbench of the quadrature position decoder
`timescale 1ns/100ps
module tb_top
	import qdec_pkg::*;
;
	localparam logic [ADDR_W-1:0] A_CTRL = 4'h0, A_LIMIT = 4'h1, A_POS = 4'h2, A_STAT = 4'h3, A_MASK = 4'h4;
	localparam logic [ADDR_W-1:0] A_CLR = 4'h5, A_PER = 4'h6, A_VRUN = 4'h7, A_VLAST = 4'h8, A_DIR = 4'h9;
	localparam logic [ADDR_W-1:0] A_MSTAT = 4'ha;
	localparam logic [DATA_W-1:0] C_EN = 32'h1 << CTL_ENABLE, C_BOTH = 32'h1 << CTL_BOTH_EDGES;
	localparam logic [DATA_W-1:0] C_IDX = 32'h1 << CTL_INDEX_RESET, C_STEP = 32'h1 << CTL_STEP_DIR;
	localparam logic [DATA_W-1:0] C_SWAP = 32'h1 << CTL_SWAP, C_VEL = 32'h1 << CTL_VEL_EN;
	logic clk_sys, arst_n, ph1, ph2, idx, reg_write, reg_read, irq;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata, rv;
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	qdec_top i_qdec_top (.clk_sys(clk_sys), .arst_n(arst_n), .phase_input_first(ph1), .phase_input_second(ph2),
		.index_in(idx), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .irq(irq));
	enc_model i_enc_model (.phase_a(ph1), .phase_b(ph2), .index_out(idx), .clk_sys(clk_sys));
	// 40 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Cut a hang short well above the thousand or so cycles the run needs
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 6000) begin
			mismatches++;
			$display("MISMATCH t=%0t run did not finish", $time);
			give_verdict();
		end
	end
	task automatic chk32(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk_sys);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_write <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so look just past that edge
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge clk_sys);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_read <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		rd(a);
		chk32(rv, exp);
	endtask
	// Mode changes go in with the decoder stopped, then enable follows
	task automatic cfg(input logic [DATA_W-1:0] v);
		wr(A_CTRL, v & ~C_EN);
		wr(A_CTRL, v);
	endtask
	// Poll until a velocity period ends, then acknowledge it
	task automatic wait_tick();
		int n;
		n = 0;
		rv = '0;
		while (rv[EV_TIMER] !== 1'b1 && n < 300) begin
			rd(A_STAT);
			n++;
		end
		chk1(rv[EV_TIMER], 1'b1);
		wr(A_CLR, 32'h1 << EV_TIMER);
	endtask
	task automatic done_test(input string s);
		$display("test %s done", s);
	endtask
	// Main sequence
	initial begin
		arst_n = 1'b0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		rdc(A_LIMIT, RESET_LIMIT);
		rdc(A_POS, 32'h0);
		rdc(A_DIR, DIR_FWD);
		rdc(A_PER, RESET_PERIOD);
		rdc(4'hf, 32'h0);
		repeat (2) i_enc_model.step(1'b0);
		rdc(A_POS, 32'h0);
		rdc(A_STAT, 32'h0);
		done_test("reset and disabled");
		wr(A_LIMIT, 32'h5);
		cfg(C_EN | C_BOTH);
		repeat (4) i_enc_model.step(1'b0);
		rdc(A_POS, 32'h4);
		repeat (2) i_enc_model.step(1'b0);
		rdc(A_POS, 32'h0);
		i_enc_model.step(1'b1);
		rdc(A_POS, 32'h5);
		repeat (20) @(posedge clk_sys);
		rdc(A_DIR, DIR_REV);
		rd(A_STAT);
		chk1(rv[EV_DIR], 1'b1);
		chk1(rv[STAT_DIR_BIT], 1'b1);
		done_test("counting and wrap");
		cfg(C_EN);
		wr(A_POS, 32'h0);
		repeat (4) i_enc_model.step(1'b0);
		rdc(A_POS, 32'h2);
		cfg(C_EN | C_BOTH | C_SWAP);
		wr(A_POS, 32'h3);
		i_enc_model.step(1'b0);
		rdc(A_POS, 32'h2);
		cfg(C_EN | C_STEP);
		wr(A_POS, 32'h3);
		i_enc_model.sd(1'b0);
		i_enc_model.sd(1'b0);
		i_enc_model.sd(1'b1);
		rdc(A_POS, 32'h4);
		done_test("edges swap and step mode");
		cfg(C_EN | C_BOTH);
		wr(A_POS, 32'h3);
		wr(A_CLR, 32'hf);
		i_enc_model.both();
		rdc(A_POS, 32'h3);
		rd(A_STAT);
		chk1(rv[EV_ERROR], 1'b1);
		chk1(rv[STAT_ERRFLAG_BIT], 1'b1);
		i_enc_model.idx();
		rdc(A_POS, 32'h3);
		wr(A_MASK, 32'h1 << EV_INDEX);
		repeat (2) @(posedge clk_sys);
		#1 chk1(irq, 1'b1);
		rdc(A_MSTAT, 32'h1 << EV_INDEX);
		wr(A_CLR, 32'h1 << EV_INDEX);
		rd(A_STAT);
		chk32(rv & 32'hf, 32'h1 << EV_ERROR);
		repeat (2) @(posedge clk_sys);
		#1 chk1(irq, 1'b0);
		done_test("error index and events");
		cfg(C_EN | C_BOTH | C_IDX);
		i_enc_model.step(1'b0);
		i_enc_model.idx();
		rdc(A_POS, 32'h0);
		repeat (2) i_enc_model.step(1'b1);
		i_enc_model.idx();
		rdc(A_POS, 32'h5);
		done_test("index reset");
		wr(A_PER, 32'h000000c8);
		cfg(C_EN | C_BOTH | C_VEL | (32'h1 << CTL_PREDIV_LSB));
		wait_tick();
		repeat (4) i_enc_model.step(1'b0);
		rdc(A_VRUN, 32'h2);
		wait_tick();
		rdc(A_VLAST, 32'h2);
		cfg(C_VEL);
		wr(A_CLR, 32'hf);
		repeat (2) i_enc_model.step(1'b0);
		repeat (450) @(posedge clk_sys);
		rd(A_STAT);
		chk1(rv[EV_TIMER], 1'b0);
		done_test("velocity");
		give_verdict();
	end
endmodule // tb_top
